// ===== logic/iatc_defs.svh
// Timing counts, widths and fixed defaults of the acquisition sequencer
`ifndef IATC_DEFS_SVH
`define IATC_DEFS_SVH

// Clock rate and microsecond tick
`define IATC_CLK_MHZ 50
`define IATC_CYC_PER_US `IATC_CLK_MHZ
`define IATC_US_DIV_W 6

// Field widths
`define IATC_CNT_W 16
`define IATC_US_W 24
`define IATC_ORG_W 8

// Frame period used without the manual rate switch, and auto-once frame count
`define IATC_AUTO_RATE_US 24'h002710
`define IATC_AUTO_ONCE_FRAMES 16'h0004

`endif

// ===== logic/iatc_pkg.sv
// Types of the image acquisition trigger control block
package iatc_pkg;

  // Capture run policy
  typedef enum logic [1:0] {
    IATC_RUN_CONT,
    IATC_RUN_COUNTED,
    IATC_RUN_SINGLE
  } iatc_run_type;

  // Trigger kind
  typedef enum logic [1:0] {
    IATC_KIND_ACQ,
    IATC_KIND_FRAME,
    IATC_KIND_BURST
  } iatc_kind_type;

  // Trigger origin
  typedef enum logic [2:0] {
    IATC_ORG_LINE,
    IATC_ORG_USER,
    IATC_ORG_COUNTER,
    IATC_ORG_LOGIC,
    IATC_ORG_HOST
  } iatc_origin_type;

  // Trigger sense
  typedef enum logic [2:0] {
    IATC_SENSE_LOW,
    IATC_SENSE_HIGH,
    IATC_SENSE_FALL,
    IATC_SENSE_RISE,
    IATC_SENSE_ANY
  } iatc_sense_type;

  // Auto shutter policy
  typedef enum logic [1:0] {
    IATC_AUTO_OFF,
    IATC_AUTO_ONCE,
    IATC_AUTO_CONT
  } iatc_auto_type;

endpackage

// ===== logic/iatc_trig_qual.sv
// Trigger origin selection and sense qualification
`timescale 1ns/1ps
`include "iatc_defs.svh"

module iatc_trig_qual (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [`IATC_ORG_W-1:0] line_i,
  input wire logic [`IATC_ORG_W-1:0] user_i,
  input wire logic [`IATC_ORG_W-1:0] counter_i,
  input wire logic [`IATC_ORG_W-1:0] logic_blk_i,
  input wire logic [2:0] origin_index_i,
  input wire iatc_pkg::iatc_origin_type origin_i,
  input wire iatc_pkg::iatc_sense_type sense_i,
  input wire logic host_trigger_cmd_i,
  output logic active_o,
  output logic event_o,
  output logic release_o
);

  logic raw;
  logic prev;
  logic next_prev;

  // --------------------------------------------------------------
  // Origin selection
  // --------------------------------------------------------------
  always_comb begin
    case (origin_i)
      iatc_pkg::IATC_ORG_LINE: raw = line_i[origin_index_i];
      iatc_pkg::IATC_ORG_USER: raw = user_i[origin_index_i];
      iatc_pkg::IATC_ORG_COUNTER: raw = counter_i[origin_index_i];
      iatc_pkg::IATC_ORG_LOGIC: raw = logic_blk_i[origin_index_i];
      default: raw = 1'b0; // Host origin uses the command pulse
    endcase
  end

  // Previous level for edge detection
  always_comb begin
    next_prev = raw;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev <= 1'b0;
    end else begin
      prev <= next_prev;
    end
  end

  // --------------------------------------------------------------
  // Sense qualification
  // --------------------------------------------------------------
  always_comb begin
    active_o = 1'b0;
    event_o = 1'b0;
    release_o = 1'b0;
    if (origin_i == iatc_pkg::IATC_ORG_HOST) begin
      event_o = host_trigger_cmd_i;
      active_o = host_trigger_cmd_i;
      release_o = host_trigger_cmd_i;
    end else begin
      case (sense_i)
        iatc_pkg::IATC_SENSE_LOW: begin
          active_o = ~raw;
          event_o = ~raw;
          release_o = raw & ~prev;
        end
        iatc_pkg::IATC_SENSE_HIGH: begin
          active_o = raw;
          event_o = raw;
          release_o = ~raw & prev;
        end
        iatc_pkg::IATC_SENSE_FALL: begin
          active_o = ~raw;
          event_o = ~raw & prev;
          release_o = raw & ~prev;
        end
        iatc_pkg::IATC_SENSE_RISE: begin
          active_o = raw;
          event_o = raw & ~prev;
          release_o = ~raw & prev;
        end
        default: begin
          active_o = raw ^ prev;
          event_o = raw ^ prev;
          release_o = raw ^ prev;
        end
      endcase
    end
  end

endmodule // iatc_trig_qual

// ===== logic/iatc_seq.sv
// Acquisition and trigger sequencer top
//
// Overview of operation
// - Continuous, counted, single policies; continuous at reset
// - Counted run stops after quantity images
// - Single run stops after one image
// - Begin and end commands start, stop capture
// - Manual switch paces at requested rate
// - Report achieved rate, slower on long exposure
// - Fixed or pulse-width exposure; fixed at reset
// - Fixed exposure lasts programmed microseconds
// - Auto once reverts to off; continuous default
// - Triggers honoured only with gate on
// - Acquisition-start trigger begins selected policy
// - Frame-start single/counted needs new begin
// - Frame-start continuous: one image per trigger
// - Burst-start continuous: burst quantity per trigger
// - Burst quantity overridden by single, counted
// - Origin from lines, outputs, counters, logic, host
// - Non-host origin qualified by programmable sense
// - Overlap policy decides triggers during readout
// - Wait trigger latency before exposure
// - Each host trigger write is one event
`timescale 1ns/1ps
`include "iatc_defs.svh"

module iatc_seq (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire iatc_pkg::iatc_run_type capture_run_policy_i,
  input wire logic [`IATC_CNT_W-1:0] multi_capture_quantity_i,
  input wire logic [`IATC_CNT_W-1:0] burst_quantity_i,
  input wire logic begin_capture_cmd_i,
  input wire logic end_capture_cmd_i,
  input wire logic manual_rate_switch_i,
  input wire logic [`IATC_US_W-1:0] requested_period_us_i,
  input wire logic exposure_policy_i,
  input wire logic [`IATC_US_W-1:0] shutter_duration_us_i,
  input wire iatc_pkg::iatc_auto_type auto_shutter_policy_i,
  input wire logic auto_shutter_write_i,
  input wire logic [`IATC_US_W-1:0] auto_shutter_us_i,
  input wire logic trigger_gate_switch_i,
  input wire iatc_pkg::iatc_kind_type trigger_kind_select_i,
  input wire iatc_pkg::iatc_origin_type trigger_origin_select_i,
  input wire logic [2:0] origin_index_i,
  input wire iatc_pkg::iatc_sense_type trigger_sense_select_i,
  input wire logic overlap_policy_i,
  input wire logic [`IATC_US_W-1:0] trigger_latency_us_i,
  input wire logic host_trigger_cmd_i,
  input wire logic [`IATC_ORG_W-1:0] line_i,
  input wire logic [`IATC_ORG_W-1:0] user_i,
  input wire logic [`IATC_ORG_W-1:0] counter_i,
  input wire logic [`IATC_ORG_W-1:0] logic_blk_i,
  input wire logic readout_busy_i,
  output logic acquiring_o,
  output logic exposing_o,
  output logic frame_done_o,
  output iatc_pkg::iatc_auto_type auto_shutter_state_o,
  output logic [`IATC_US_W-1:0] achieved_period_us_o
);

  typedef enum logic [2:0] {
    IATC_ST_IDLE,
    IATC_ST_ARMED,
    IATC_ST_DELAY,
    IATC_ST_EXPOSE,
    IATC_ST_GAP
  } iatc_state_type;

  // Frames to take for one run or trigger
  function automatic logic [`IATC_CNT_W-1:0] quota_for(
    input iatc_pkg::iatc_run_type run,
    input logic [`IATC_CNT_W-1:0] cont_quota
  );
    if (run == iatc_pkg::IATC_RUN_SINGLE) begin
      quota_for = `IATC_CNT_W'(1);
    end else if (run == iatc_pkg::IATC_RUN_COUNTED) begin
      quota_for = multi_capture_quantity_i;
    end else begin
      quota_for = cont_quota;
    end
  endfunction

  iatc_state_type state;
  iatc_state_type next_state;
  logic running;
  logic next_running;
  logic [`IATC_CNT_W-1:0] remain;
  logic [`IATC_CNT_W-1:0] next_remain;
  logic [`IATC_US_W-1:0] us_cnt;
  logic [`IATC_US_W-1:0] next_us_cnt;
  logic [`IATC_US_W-1:0] frame_us;
  logic [`IATC_US_W-1:0] next_frame_us;
  logic [`IATC_US_W-1:0] achieved;
  logic [`IATC_US_W-1:0] next_achieved;
  logic [`IATC_US_DIV_W-1:0] div;
  logic [`IATC_US_DIV_W-1:0] next_div;
  iatc_pkg::iatc_auto_type auto_st;
  iatc_pkg::iatc_auto_type next_auto_st;
  logic [`IATC_CNT_W-1:0] once_left;
  logic [`IATC_CNT_W-1:0] next_once_left;
  logic done;
  logic next_done;
  logic trig_active;
  logic trig_event;
  logic trig_release;
  logic tick_us;
  logic trig_ok;
  logic [`IATC_US_W-1:0] period_us;
  logic [`IATC_US_W-1:0] expose_us;

  // --------------------------------------------------------------
  // Trigger qualification
  // --------------------------------------------------------------
  iatc_trig_qual u_qual (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .line_i(line_i),
    .user_i(user_i),
    .counter_i(counter_i),
    .logic_blk_i(logic_blk_i),
    .origin_index_i(origin_index_i),
    .origin_i(trigger_origin_select_i),
    .sense_i(trigger_sense_select_i),
    .host_trigger_cmd_i(host_trigger_cmd_i),
    .active_o(trig_active),
    .event_o(trig_event),
    .release_o(trig_release)
  );

  // Microsecond tick from the divider
  always_comb begin
    tick_us = (div == `IATC_US_DIV_W'(`IATC_CYC_PER_US - 1));
  end

  // Gate, overlap and period selection
  always_comb begin
    trig_ok = trigger_gate_switch_i & trig_event &
              (overlap_policy_i | ~readout_busy_i);
    period_us = manual_rate_switch_i ? requested_period_us_i
                                     : `IATC_AUTO_RATE_US;
    expose_us = (auto_st == iatc_pkg::IATC_AUTO_OFF) ?
                shutter_duration_us_i : auto_shutter_us_i;
  end

  // --------------------------------------------------------------
  // Sequencer next state
  // --------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_running = running;
    next_remain = remain;
    next_us_cnt = tick_us ? us_cnt + `IATC_US_W'(1) : us_cnt;
    next_frame_us = tick_us ? frame_us + `IATC_US_W'(1) : frame_us;
    next_achieved = achieved;
    next_done = 1'b0;
    if (end_capture_cmd_i) begin
      next_state = IATC_ST_IDLE;
      next_running = 1'b0;
      next_remain = '0;
    end else begin
      case (state)
        IATC_ST_IDLE: begin
          if (begin_capture_cmd_i) begin
            next_running = 1'b1;
            next_us_cnt = '0;
            next_frame_us = '0;
            if (trigger_gate_switch_i) begin
              next_state = IATC_ST_ARMED;
            end else begin
              next_remain = quota_for(capture_run_policy_i, '0);
              next_state = IATC_ST_EXPOSE;
            end
          end
        end
        IATC_ST_ARMED: begin
          if (trig_ok) begin
            next_us_cnt = '0;
            next_state = IATC_ST_DELAY;
            if (trigger_kind_select_i == iatc_pkg::IATC_KIND_ACQ) begin
              next_remain = quota_for(capture_run_policy_i, '0);
            end else if (trigger_kind_select_i ==
                         iatc_pkg::IATC_KIND_FRAME) begin
              next_remain = quota_for(capture_run_policy_i,
                                      `IATC_CNT_W'(1));
            end else begin
              next_remain = quota_for(capture_run_policy_i,
                                      burst_quantity_i);
            end
          end
        end
        IATC_ST_DELAY: begin
          if (us_cnt >= trigger_latency_us_i) begin
            next_us_cnt = '0;
            next_state = IATC_ST_EXPOSE;
          end
        end
        IATC_ST_EXPOSE: begin
          if (exposure_policy_i ? (trig_release | ~trig_active)
                                : (next_us_cnt >= expose_us)) begin
            next_done = 1'b1;
            next_state = IATC_ST_GAP;
            if (remain != '0) begin
              next_remain = remain - `IATC_CNT_W'(1);
            end
          end
        end
        default: begin
          if (next_frame_us >= period_us) begin
            next_achieved = next_frame_us;
            next_frame_us = '0;
            next_us_cnt = '0;
            if (remain != '0) begin
              next_state = IATC_ST_EXPOSE;
            end else if (trigger_gate_switch_i &&
                         capture_run_policy_i == iatc_pkg::IATC_RUN_CONT &&
                         trigger_kind_select_i !=
                         iatc_pkg::IATC_KIND_ACQ) begin
              next_state = IATC_ST_ARMED;
            end else if (capture_run_policy_i ==
                         iatc_pkg::IATC_RUN_CONT) begin
              next_state = IATC_ST_EXPOSE;
            end else begin
              next_state = IATC_ST_IDLE;
              next_running = 1'b0;
            end
          end
        end
      endcase
    end
    // Divider restarts on state change, so spans are whole microseconds
    next_div = (tick_us || next_state != state) ? '0
                                                 : div + `IATC_US_DIV_W'(1);
  end

  // Auto shutter policy tracking
  always_comb begin
    next_auto_st = auto_st;
    next_once_left = once_left;
    if (auto_shutter_write_i) begin
      next_auto_st = auto_shutter_policy_i;
      next_once_left = `IATC_AUTO_ONCE_FRAMES;
    end else if (auto_st == iatc_pkg::IATC_AUTO_ONCE && next_done) begin
      if (once_left <= `IATC_CNT_W'(1)) begin
        next_auto_st = iatc_pkg::IATC_AUTO_OFF;
      end
      next_once_left = once_left - `IATC_CNT_W'(1);
    end
  end

  // --------------------------------------------------------------
  // State registers
  // --------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= IATC_ST_IDLE;
      running <= 1'b0;
      remain <= '0;
      us_cnt <= '0;
      frame_us <= '0;
      achieved <= '0;
      div <= '0;
      done <= 1'b0;
      auto_st <= iatc_pkg::IATC_AUTO_CONT;
      once_left <= '0;
    end else begin
      state <= next_state;
      running <= next_running;
      remain <= next_remain;
      us_cnt <= next_us_cnt;
      frame_us <= next_frame_us;
      achieved <= next_achieved;
      div <= next_div;
      done <= next_done;
      auto_st <= next_auto_st;
      once_left <= next_once_left;
    end
  end

  // Outputs
  always_comb begin
    acquiring_o = running;
    exposing_o = (state == IATC_ST_EXPOSE);
    frame_done_o = done;
    auto_shutter_state_o = auto_st;
    achieved_period_us_o = achieved;
  end

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  chk_end_idles: assert property (@(posedge clk_i) disable iff (rst_i)
    end_capture_cmd_i |=> (state == IATC_ST_IDLE) && !running)
    else $error("end command did not idle");

  chk_gate_blocks: assert property (@(posedge clk_i)
    disable iff (rst_i) (state == IATC_ST_ARMED) && !trigger_gate_switch_i
    && !end_capture_cmd_i |=> state == IATC_ST_ARMED)
    else $error("trigger taken with gate off");

  chk_overlap_drop: assert property (@(posedge clk_i)
    disable iff (rst_i) (state == IATC_ST_ARMED) && readout_busy_i
    && !overlap_policy_i && !end_capture_cmd_i |=> state == IATC_ST_ARMED)
    else $error("trigger taken during readout");

  chk_single_stop: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == IATC_ST_GAP) && (next_state == IATC_ST_IDLE)
    && !end_capture_cmd_i |-> remain == '0)
    else $error("run stopped with frames left");

  chk_begin_runs: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == IATC_ST_IDLE) && begin_capture_cmd_i && !end_capture_cmd_i
    |=> running)
    else $error("begin command ignored");

  chk_auto_reset: assert property (@(posedge clk_i)
    $fell(rst_i) |-> auto_st == iatc_pkg::IATC_AUTO_CONT)
    else $error("auto shutter reset value wrong");

  chk_rate_floor: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(achieved) |-> achieved >= period_us)
    else $error("achieved period below request");

  chk_expose_done: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == IATC_ST_EXPOSE) && !exposure_policy_i
    && (expose_us != '0) && !end_capture_cmd_i
    |-> us_cnt < expose_us)
    else $error("fixed exposure overran");

endmodule // iatc_seq

// ===== verif/iatc_src_model.sv
// Trigger source and sensor readout model at the far side of the sequencer
`timescale 1ns/1ps
module iatc_src_model #(
  parameter int HOLD = 20,
  parameter int READ = 400
) (
  input wire logic clk_i,
  input wire logic fire_i,
  input wire logic [2:0] idx_i,
  input wire logic frame_done_i,
  output logic [7:0] src_o,
  output logic readout_busy_o
);
  logic fire_q = 1'b0;
  logic done_q = 1'b0;
  int hold_cnt = 0;
  int read_cnt = 0;
  // Sample requests on the rising edge
  always @(posedge clk_i) begin
    fire_q <= fire_i;
    done_q <= frame_done_i;
  end
  // Move source pulse and readout span off the sampling edge
  always @(negedge clk_i) begin
    if (fire_q) hold_cnt = HOLD;
    else if (hold_cnt > 0) hold_cnt = hold_cnt - 1;
    if (done_q) read_cnt = READ;
    else if (read_cnt > 0) read_cnt = read_cnt - 1;
  end
  // Selected bit pulses high, idle sources rest low
  assign src_o = (hold_cnt > 0) ? (8'h01 << idx_i) : 8'h00;
  assign readout_busy_o = (read_cnt > 0);
endmodule // iatc_src_model

// ===== verif/test_iatc_seq.sv
// Self-checking bench of the acquisition and trigger sequencer
`timescale 1ns/1ps
`include "iatc_defs.svh"
module test_iatc_seq;
  localparam int PER = 200; // Cycles of one 4 us frame period
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  iatc_pkg::iatc_run_type capture_run_policy_i = iatc_pkg::IATC_RUN_CONT;
  logic [`IATC_CNT_W-1:0] multi_capture_quantity_i = 16'h0003;
  logic [`IATC_CNT_W-1:0] burst_quantity_i = 16'h0002;
  logic begin_capture_cmd_i = 1'b0;
  logic end_capture_cmd_i = 1'b0;
  logic manual_rate_switch_i = 1'b1;
  logic [`IATC_US_W-1:0] requested_period_us_i = 24'h000004;
  logic exposure_policy_i = 1'b0;
  logic [`IATC_US_W-1:0] shutter_duration_us_i = 24'h000001;
  iatc_pkg::iatc_auto_type auto_shutter_policy_i = iatc_pkg::IATC_AUTO_OFF;
  logic auto_shutter_write_i = 1'b0;
  logic [`IATC_US_W-1:0] auto_shutter_us_i = 24'h000001;
  logic trigger_gate_switch_i = 1'b0;
  iatc_pkg::iatc_kind_type trigger_kind_select_i =
    iatc_pkg::IATC_KIND_FRAME;
  iatc_pkg::iatc_origin_type trigger_origin_select_i =
    iatc_pkg::IATC_ORG_HOST;
  logic [2:0] origin_index_i = 3'h3;
  iatc_pkg::iatc_sense_type trigger_sense_select_i =
    iatc_pkg::IATC_SENSE_RISE;
  logic overlap_policy_i = 1'b0;
  logic [`IATC_US_W-1:0] trigger_latency_us_i = 24'h000002;
  logic host_trigger_cmd_i = 1'b0;
  logic fire = 1'b0;
  logic [7:0] src;
  logic readout_busy_i;
  logic acquiring_o;
  logic exposing_o;
  logic frame_done_o;
  iatc_pkg::iatc_auto_type auto_shutter_state_o;
  logic [`IATC_US_W-1:0] achieved_period_us_o;
  int errors = 0;
  int compares = 0;
  int frames = 0;
  int run_len = 0;
  int last_exp = 0;

  iatc_seq DUT (
    .clk_i, .rst_i, .capture_run_policy_i, .multi_capture_quantity_i,
    .burst_quantity_i, .begin_capture_cmd_i, .end_capture_cmd_i,
    .manual_rate_switch_i, .requested_period_us_i, .exposure_policy_i,
    .shutter_duration_us_i, .auto_shutter_policy_i, .auto_shutter_write_i,
    .auto_shutter_us_i, .trigger_gate_switch_i, .trigger_kind_select_i,
    .trigger_origin_select_i, .origin_index_i, .trigger_sense_select_i,
    .overlap_policy_i, .trigger_latency_us_i, .host_trigger_cmd_i,
    .line_i(src), .user_i(src), .counter_i(src), .logic_blk_i(src),
    .readout_busy_i, .acquiring_o, .exposing_o, .frame_done_o,
    .auto_shutter_state_o, .achieved_period_us_o
  );

  iatc_src_model #(.HOLD(20), .READ(400)) src_model (
    .clk_i(clk_i), .fire_i(fire), .idx_i(origin_index_i),
    .frame_done_i(frame_done_o), .src_o(src),
    .readout_busy_o(readout_busy_i)
  );

  // 50 MHz clock
  initial begin
    forever #10 clk_i = ~clk_i;
  end

  // Tally of finished frames and length of the last exposure
  always @(posedge clk_i) begin
    if (frame_done_o === 1'b1) frames++;
    if (exposing_o === 1'b1) run_len++;
    else if (run_len > 0) begin
      last_exp = run_len;
      run_len = 0;
    end
  end

  task automatic step(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle command pulse: begin, end, host, source, auto write
  task automatic cmd(input int k);
    @(negedge clk_i);
    case (k)
      0: begin_capture_cmd_i = 1'b1;
      1: end_capture_cmd_i = 1'b1;
      2: host_trigger_cmd_i = 1'b1;
      3: fire = 1'b1;
      default: auto_shutter_write_i = 1'b1;
    endcase
    @(negedge clk_i);
    {begin_capture_cmd_i, end_capture_cmd_i, host_trigger_cmd_i} = 3'h0;
    {fire, auto_shutter_write_i} = 2'h0;
  endtask

  task automatic end_sim();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic t_reset();
    chk(acquiring_o, 1'b0);
    chk(exposing_o, 1'b0);
    chk(auto_shutter_state_o, iatc_pkg::IATC_AUTO_CONT);
    chk(achieved_period_us_o, 24'h000000);
    cmd(4);
    step(1);
    chk(auto_shutter_state_o, iatc_pkg::IATC_AUTO_OFF);
    $display("test reset done");
  endtask

  task automatic t_run(input iatc_pkg::iatc_run_type p, input int n);
    capture_run_policy_i = p;
    frames = 0;
    cmd(0);
    step(1);
    chk(acquiring_o, 1'b1);
    step(4 * PER);
    chk(frames, n);
    chk(acquiring_o, 1'b0);
    chk(last_exp, 50);
    if (n > 1) chk(achieved_period_us_o, 24'h000004);
    $display("test run policy %0d done", p);
  endtask

  task automatic t_stop();
    int f;
    capture_run_policy_i = iatc_pkg::IATC_RUN_CONT;
    cmd(0);
    step(5 * PER / 2);
    cmd(1);
    step(1);
    chk(acquiring_o, 1'b0);
    f = frames;
    step(3 * PER);
    chk(frames, f);
    $display("test stop done");
  endtask

  task automatic t_long();
    shutter_duration_us_i = 24'h000006;
    cmd(0);
    step(8 * PER);
    chk(achieved_period_us_o >= 24'h000006, 1'b1);
    cmd(1);
    step(2 * PER);
    shutter_duration_us_i = 24'h000001;
    auto_shutter_policy_i = iatc_pkg::IATC_AUTO_ONCE;
    cmd(4);
    step(1);
    chk(auto_shutter_state_o, iatc_pkg::IATC_AUTO_ONCE);
    cmd(0);
    step(6 * PER);
    chk(auto_shutter_state_o, iatc_pkg::IATC_AUTO_OFF);
    cmd(1);
    step(2 * PER);
    $display("test long exposure and auto once done");
  endtask

  task automatic t_trig();
    int n;
    int f;
    trigger_gate_switch_i = 1'b1;
    frames = 0;
    cmd(0);
    step(2 * PER);
    chk(frames, 0);
    cmd(2);
    n = 1;
    while (exposing_o !== 1'b1 && n < 400) begin
      step(1);
      n++;
    end
    chk(n >= 100 && n <= 155, 1'b1);
    step(3 * PER);
    cmd(2);
    step(3 * PER);
    chk(frames, 2);
    for (int o = 0; o < 4; o++) begin
      trigger_origin_select_i = iatc_pkg::iatc_origin_type'(o);
      f = frames;
      cmd(3);
      step(4 * PER);
      chk(frames, f + 1);
    end
    $display("test triggered frames done");
  endtask

  task automatic t_ovl(input logic pol, input int n);
    int f;
    overlap_policy_i = pol;
    f = frames;
    cmd(3);
    step(2 * PER);
    cmd(3);
    step(4 * PER);
    chk(frames, f + n);
    $display("test overlap %0d done", pol);
  endtask

  // Pulse-width exposure on a level-high logic source: 20-cycle pulse, one cycle
  // spent in the zero-latency delay state, so 19 exposing cycles
  task automatic t_width();
    int f;
    exposure_policy_i = 1'b1;
    trigger_latency_us_i = 24'h000000;
    trigger_sense_select_i = iatc_pkg::IATC_SENSE_HIGH;
    f = frames;
    cmd(3);
    step(100);
    chk(frames, f + 1);
    chk(last_exp, 19);
    exposure_policy_i = 1'b0;
    trigger_latency_us_i = 24'h000002;
    trigger_sense_select_i = iatc_pkg::IATC_SENSE_RISE;
    $display("test pulse width done");
  endtask

  // Host trigger under a kind and policy; finite runs refuse a retrigger
  task automatic t_kind(input iatc_pkg::iatc_kind_type k,
                        input iatc_pkg::iatc_run_type p, input int n);
    int f;
    cmd(1);
    step(4);
    capture_run_policy_i = p;
    trigger_kind_select_i = k;
    trigger_origin_select_i = iatc_pkg::IATC_ORG_HOST;
    cmd(0);
    step(4);
    f = frames;
    cmd(2);
    step(5 * PER);
    chk(frames, f + n);
    if (p != iatc_pkg::IATC_RUN_CONT) begin
      cmd(2);
      step(2 * PER);
      chk(frames, f + n);
    end
    $display("test trigger kind %0d policy %0d done", k, p);
  endtask

  // Main sequence
  initial begin
    step(16);
    rst_i = 1'b0;
    t_reset();
    t_run(iatc_pkg::IATC_RUN_COUNTED, 3);
    t_run(iatc_pkg::IATC_RUN_SINGLE, 1);
    t_stop();
    t_long();
    t_trig();
    t_ovl(1'b0, 1);
    t_ovl(1'b1, 2);
    t_width();
    t_kind(iatc_pkg::IATC_KIND_BURST, iatc_pkg::IATC_RUN_CONT, 2);
    t_kind(iatc_pkg::IATC_KIND_BURST, iatc_pkg::IATC_RUN_SINGLE, 1);
    t_kind(iatc_pkg::IATC_KIND_BURST, iatc_pkg::IATC_RUN_COUNTED, 3);
    t_kind(iatc_pkg::IATC_KIND_FRAME, iatc_pkg::IATC_RUN_COUNTED, 3);
    t_kind(iatc_pkg::IATC_KIND_ACQ, iatc_pkg::IATC_RUN_SINGLE, 1);
    end_sim();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (60000) @(posedge clk_i);
    errors++;
    end_sim();
  end
endmodule // test_iatc_seq
